// file: rtl/fci_host.sv
// fci_host: host controller issuing flash command sequences
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - extra block addresses within 96 us window
// - temporary protection: single absolute write from flash
// - protection fourth cycle uses address 4n-2
// - command sequences never fetched from flash
// - effective address includes segment, indirect only
// - all addresses inside active flash space
// - clear segmentation disable for full memory
// - enabling code runs above 00'8000h or RAM
// - jump absolutely after enabling the flash
// - A15, A14 match page pointer low bits
module fci_host import fci_pkg::*; #(
  parameter int WIN_CYCLES = WIN_CYC,
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [23:0] fl_addr,
  output logic [15:0] fl_wdata,
  output logic fl_wr,
  output logic fl_rd,
  input wire logic [15:0] fl_rdata,
  input wire logic fl_ack,
  output logic internal_memory_enable,
  output logic low_block_remap,
  output logic segmentation_disable
);
  // ----------------------------------------------------------------
  // sequence tables
  // ----------------------------------------------------------------
  function automatic logic [2:0] nsteps(input logic [3:0] op);
    case (op)
      OP_RESET: nsteps = 3'h3;
      OP_PROG, OP_SETP, OP_RDP, OP_BTU: nsteps = 3'h4;
      OP_BERASE, OP_CERASE: nsteps = 3'h6;
      OP_SUSP, OP_RESUME, OP_CTU, OP_CTP, OP_ADDBLK, OP_READ: nsteps = 3'h1;
      default: nsteps = 3'h0;
    endcase
  endfunction

  function automatic logic uses_tgt(input logic [3:0] op);
    uses_tgt = !(op == OP_RESET || op == OP_CERASE || op == OP_SUSP ||
                 op == OP_RESUME || op == OP_BTU);
  endfunction

  // final cycle of each operation: {kind, offset, data}
  function automatic logic [33:0] last_step(input logic [3:0] op);
    case (op)
      OP_PROG, OP_SETP: last_step = {K_TDATA, ZERO16, ZERO16};
      OP_BERASE, OP_ADDBLK: last_step = {K_TCODE, ZERO16, C_BLK};
      OP_CERASE: last_step = {K_CMD, OFF_A, C_CHIP};
      OP_RDP, OP_READ: last_step = {K_TREAD, ZERO16, ZERO16};
      OP_BTU: last_step = {K_CMD, OFF_C, C_BTU2};
      OP_SUSP: last_step = {K_CMD, OFF_A, C_SUSP};
      OP_RESUME: last_step = {K_CMD, OFF_A, C_RESUME};
      // temporary protection is one flash write
      OP_CTU: last_step = {K_TCODE, ZERO16, C_CTU};
      OP_CTP: last_step = {K_TCODE, ZERO16, C_CTP};
      default: last_step = {K_CMD, OFF_A, C_RESET};
    endcase
  endfunction

  // unlock prefix, command code, second unlock for erase
  function automatic logic [33:0] step_info(input logic [3:0] op, input logic [2:0] i);
    logic prot;
    logic [15:0] code;
    prot = (op == OP_SETP) || (op == OP_RDP) || (op == OP_BTU);
    case (op)
      OP_RESET: code = C_RESET;
      OP_PROG: code = C_PROG;
      OP_SETP: code = C_SETP;
      OP_RDP: code = C_RDP;
      OP_BTU: code = C_BTU;
      default: code = C_ERASE;
    endcase
    if (i == nsteps(op) - 3'h1) begin
      step_info = last_step(op);
    end else if (i == 3'h0 || i == 3'h3) begin
      step_info = {K_CMD, prot ? OFF_C : OFF_A, C_UNLK1};
    end else if (i == 3'h1 || i == 3'h4) begin
      step_info = {K_CMD, prot ? OFF_D : OFF_B, C_UNLK2};
    end else begin
      step_info = {K_CMD, prot ? OFF_C : OFF_A, code};
    end
  endfunction

  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      bmerge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic reg_we;
  logic [AW-1:0] reg_waddr;
  logic [AW-1:0] reg_raddr;
  logic [31:0] reg_wdata;
  logic [3:0] reg_wstrb;
  logic reg_wok;
  logic [31:0] reg_rdata;
  logic reg_rok;
  logic [3:0] op_q;
  logic [23:0] taddr;
  logic [15:0] data_q;
  logic [7:0] cseg;
  logic [2:0] scfg;
  logic [3:0] err_q;
  logic [15:0] rdata_q;
  logic [2:0] idx_q;
  logic erase_ph;
  logic win_open;
  fci_state_type state;
  fci_state_type next_state;

  fci_axil #(.AW(AW)) u_axil (
    .mclk(mclk), .rstn(rstn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb), .reg_wok(reg_wok), .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata), .reg_rok(reg_rok)
  );

  // write decode; setup registers are frozen while a sequence runs
  wire idle = state == S_IDLE;
  wire hit_ctrl = reg_waddr == REG_CTRL;
  wire hit_taddr = reg_waddr == REG_TADDR;
  wire hit_data = reg_waddr == REG_DATA;
  wire hit_cseg = reg_waddr == REG_CSEG;
  wire hit_scfg = reg_waddr == REG_SCFG;
  wire setup_hit = hit_taddr || hit_data || hit_cseg || hit_scfg;
  assign reg_wok = hit_ctrl || (idle && setup_hit);
  wire wr_setup = reg_we && idle;
  wire [31:0] next_taddr = bmerge({8'h00, taddr}, reg_wdata, reg_wstrb);
  wire [31:0] next_data = bmerge({16'h0000, data_q}, reg_wdata, reg_wstrb);
  wire [31:0] next_cseg = bmerge({24'h000000, cseg}, reg_wdata, reg_wstrb);
  wire [31:0] next_scfg = bmerge({29'h00000000, scfg}, reg_wdata, reg_wstrb);

  // ----------------------------------------------------------------
  // start checks
  // ----------------------------------------------------------------
  wire go_req = reg_we && hit_ctrl && reg_wstrb[1] && reg_wdata[CTRL_GO];
  wire [3:0] go_op = reg_wstrb[0] ? reg_wdata[3:0] : op_q;
  wire bad_op = nsteps(go_op) == 3'h0;
  // command address carries the segment; lets one segment serve
  wire [23:0] cmd_base = {cseg, OFF_A};
  // command and target addresses must be mapped flash
  wire rng_ok = flash_active(cmd_base, scfg[SCFG_IME], scfg[SCFG_REMAP]) &&
                (!uses_tgt(go_op) || flash_active(taddr, scfg[SCFG_IME], scfg[SCFG_REMAP]));
  // protection cycle four needs address 4n-2
  wire odd_ok = !(go_op == OP_SETP || go_op == OP_RDP) || taddr[1:0] == ODD_TAG;
  // another block only while the window is open
  wire late_ok = go_op != OP_ADDBLK || (win_open && erase_ph);
  wire accept = go_req && idle && !bad_op && rng_ok && odd_ok && late_ok;

  // ----------------------------------------------------------------
  // step selection and sequencer
  // ----------------------------------------------------------------
  wire [3:0] sel_op = idle ? go_op : op_q;
  wire [2:0] sel_idx = idle ? 3'h0 : idx_q;
  wire [33:0] step = step_info(sel_op, sel_idx);
  wire [1:0] st_k = step[33:32];
  // segment and offset are joined as one physical address
  wire [23:0] st_addr = (st_k == K_CMD) ? {cseg, step[31:16]} : taddr;
  wire [15:0] st_data = (st_k == K_TDATA) ? data_q : step[15:0];
  wire last = idx_q == nsteps(op_q) - 3'h1;
  wire ack_done = (state == S_BUS) && fl_ack;
  wire load = accept || (state == S_GAP);
  // each block write restarts the window
  wire win_start = ack_done && last && (op_q == OP_BERASE || op_q == OP_ADDBLK);

  fci_win #(.CYC(WIN_CYCLES)) u_win (
    .mclk(mclk), .rstn(rstn), .start(win_start), .win_open(win_open)
  );

  // sequences come from logic, never flash fetches
  // one idle cycle between bus cycles of a sequence
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (accept) next_state = S_BUS;
      S_BUS: if (fl_ack) next_state = last ? S_IDLE : S_GAP;
      S_GAP: next_state = S_BUS;
      default: next_state = S_IDLE;
    endcase
  end

  // state, step index, flash bus strobes
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= S_IDLE;
      idx_q <= 3'h0;
      fl_wr <= 1'b0;
      fl_rd <= 1'b0;
    end else begin
      state <= next_state;
      if (accept) idx_q <= 3'h0;
      else if (ack_done) idx_q <= idx_q + 3'h1;
      if (load) begin
        fl_wr <= st_k != K_TREAD;
        fl_rd <= st_k == K_TREAD;
      end else if (ack_done) begin
        fl_wr <= 1'b0;
        fl_rd <= 1'b0;
      end
    end
  end

  // flash address and data held for the whole bus cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fl_addr <= '0;
      fl_wdata <= '0;
    end else if (load) begin
      fl_addr <= st_addr;
      fl_wdata <= st_data;
    end
  end

  // read word kept, bit 3 gives the window state
  always_ff @(posedge mclk) begin
    if (!rstn) rdata_q <= '0;
    else if (ack_done && fl_rd) rdata_q <= fl_rdata;
  end

  // operation, refusal flags, erase phase
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      op_q <= OP_RESET;
      err_q <= '0;
      erase_ph <= 1'b0;
    end else if (go_req && idle) begin
      err_q <= {bad_op, !late_ok, !odd_ok, !rng_ok};
      if (accept) begin
        op_q <= go_op;
        erase_ph <= go_op == OP_BERASE || go_op == OP_ADDBLK;
      end
    end
  end

  // setup registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      taddr <= '0;
      data_q <= '0;
      cseg <= '0;
      scfg <= SCFG_RST;
    end else if (wr_setup) begin
      if (hit_taddr) taddr <= next_taddr[23:0];
      if (hit_data) data_q <= next_data[15:0];
      if (hit_cseg) cseg <= next_cseg[7:0];
      if (hit_scfg) scfg <= next_scfg[2:0];
    end
  end

  assign internal_memory_enable = scfg[SCFG_IME];
  assign low_block_remap = scfg[SCFG_REMAP];
  assign segmentation_disable = scfg[SCFG_SEGDIS];

  // read decode
  always_comb begin
    reg_rdata = '0;
    reg_rok = 1'b1;
    if (reg_raddr == REG_CTRL) begin
      reg_rdata[3:0] = op_q;
    end else if (reg_raddr == REG_TADDR) begin
      reg_rdata[23:0] = taddr;
    end else if (reg_raddr == REG_DATA) begin
      reg_rdata[15:0] = data_q;
    end else if (reg_raddr == REG_CSEG) begin
      reg_rdata[7:0] = cseg;
    end else if (reg_raddr == REG_SCFG) begin
      reg_rdata[2:0] = scfg;
    end else if (reg_raddr == REG_STAT) begin
      reg_rdata[ST_BUSY] = !idle;
      reg_rdata[ST_ERR_LSB +: 4] = err_q;
      reg_rdata[ST_WIN] = win_open;
      reg_rdata[ST_ERASE] = erase_ph;
      reg_rdata[ST_RD_LSB +: 16] = rdata_q;
    end else begin
      reg_rok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  bus_hold_a: assert property (
    (fl_wr || fl_rd) && !fl_ack |=> (fl_wr || fl_rd) && $stable(fl_addr) && $stable(fl_wdata))
    else $error("bus cycle dropped before ack");
  flash_range_a: assert property (
    $rose(fl_wr || fl_rd) && uses_tgt(op_q) && last |->
      flash_active(fl_addr, scfg[SCFG_IME], scfg[SCFG_REMAP]))
    else $error("target outside flash space");
  odd_addr_a: assert property (
    $rose(fl_wr || fl_rd) && (op_q == OP_SETP || op_q == OP_RDP) && last |->
      fl_addr[1:0] == ODD_TAG)
    else $error("protection cycle not at 4n-2");
  late_block_a: assert property (
    go_req && idle && go_op == OP_ADDBLK && !win_open |=> idle && err_q[2] && !fl_wr)
    else $error("late block accepted");
  refuse_range_a: assert property (
    go_req && idle && !rng_ok |=> idle ##1 idle && err_q[0])
    else $error("out of range start not refused");
  cmd_addr_a: assert property (
    $rose(fl_wr) && op_q == OP_RESET |->
      fl_addr[23:16] == cseg && (fl_addr[15:0] == OFF_A || fl_addr[15:0] == OFF_B))
    else $error("command address malformed");
  gap_cycle_a: assert property (
    ack_done && !last |=> !fl_wr && !fl_rd ##1 (fl_wr || fl_rd))
    else $error("gap between command cycles wrong");
  win_run_a: assert property (
    win_start |=> win_open [*8])
    else $error("window not running after block write");

  prog_done_c: cover property (ack_done && last && op_q == OP_PROG);
  add_block_c: cover property (accept && go_op == OP_ADDBLK);
  prot_read_c: cover property (ack_done && fl_rd && op_q == OP_RDP);
  refused_c: cover property (go_req && idle && !accept);
endmodule // fci_host

// file: shared/fci_pkg.sv
// fci_pkg: constants and types for the flash command host controller
package fci_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int WIN_NS = 96000;            // block-add window, ns
  localparam int WIN_CYC = WIN_NS / CLK_NS; // longest time, rounded down
  // ----------------------------------------------------------------
  // controller registers (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_CSEG = 8'h0C;
  localparam logic [7:0] REG_SCFG = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam int CTRL_GO = 8;
  localparam int SCFG_IME = 0;
  localparam int SCFG_REMAP = 1;
  localparam int SCFG_SEGDIS = 2;
  localparam logic [2:0] SCFG_RST = 3'h0;
  localparam int ST_BUSY = 0;
  localparam int ST_ERR_LSB = 1;
  localparam int ST_WIN = 5;
  localparam int ST_ERASE = 6;
  localparam int ST_RD_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // operations, step kinds, command offsets and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_RESET = 4'h0, OP_PROG = 4'h1, OP_BERASE = 4'h2;
  localparam logic [3:0] OP_CERASE = 4'h3, OP_SUSP = 4'h4, OP_RESUME = 4'h5;
  localparam logic [3:0] OP_SETP = 4'h6, OP_RDP = 4'h7, OP_BTU = 4'h8;
  localparam logic [3:0] OP_CTU = 4'h9, OP_CTP = 4'hA, OP_ADDBLK = 4'hB;
  localparam logic [3:0] OP_READ = 4'hC;
  localparam logic [1:0] K_CMD = 2'h0, K_TCODE = 2'h1, K_TDATA = 2'h2, K_TREAD = 2'h3;
  localparam logic [15:0] OFF_A = 16'h1554, OFF_B = 16'h2AA8;
  localparam logic [15:0] OFF_C = 16'h2A54, OFF_D = 16'h15A8;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] C_UNLK1 = 16'h00A8, C_UNLK2 = 16'h0054;
  localparam logic [15:0] C_RESET = 16'h00F0, C_PROG = 16'h00A0;
  localparam logic [15:0] C_ERASE = 16'h0080, C_BLK = 16'h0030, C_CHIP = 16'h0010;
  localparam logic [15:0] C_SUSP = 16'h00B0, C_RESUME = 16'h0030;
  localparam logic [15:0] C_SETP = 16'h00C0, C_RDP = 16'h0090;
  localparam logic [15:0] C_BTU = 16'h00C1, C_BTU2 = 16'h00F0;
  localparam logic [15:0] C_CTU = 16'hFFFF, C_CTP = 16'hFFFB;
  localparam logic [1:0] ODD_TAG = 2'h2;
  // ----------------------------------------------------------------
  // flash address map
  // ----------------------------------------------------------------
  localparam logic [23:0] LOW_SIZE = 24'h008000;
  localparam logic [23:0] SEG1_BASE = 24'h010000;
  localparam logic [23:0] HI_LO = 24'h018000;
  localparam logic [23:0] HI_HI = 24'h04FFFF;

  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_BUS = 3'h2,
    S_GAP = 3'h4
  } fci_state_type;

  // true when a physical address lies in the mapped flash space
  function automatic logic flash_active(input logic [23:0] a, input logic ime,
                                        input logic remap);
    logic lo;
    lo = remap ? (a < LOW_SIZE) : (a >= SEG1_BASE && a < SEG1_BASE + LOW_SIZE);
    return ime && (lo || (a >= HI_LO && a <= HI_HI));
  endfunction
endpackage

// file: rtl/fci_axil.sv
// fci_axil: AXI4-Lite slave front end for the controller registers
`timescale 1ns/1ps
module fci_axil import fci_pkg::*; #(
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic reg_we,
  output logic [AW-1:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_wok,
  output logic [AW-1:0] reg_raddr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rok
);
  logic aw_full;
  logic w_full;

  // a write completes once address and data are both held
  assign awready = !aw_full;
  assign wready = !w_full;
  assign reg_we = aw_full && w_full && !bvalid;
  assign arready = !rvalid;
  assign reg_raddr = araddr;

  // write channels, taken in either order
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      reg_waddr <= '0;
      reg_wdata <= '0;
      reg_wstrb <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        reg_waddr <= awaddr;
      end else if (reg_we) begin
        aw_full <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        reg_wdata <= wdata;
        reg_wstrb <= wstrb;
      end else if (reg_we) begin
        w_full <= 1'b0;
      end
      if (reg_we) begin
        bvalid <= 1'b1;
        bresp <= reg_wok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel, data captured at the address handshake
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= reg_rdata;
      rresp <= reg_rok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // fci_axil

// file: rtl/fci_win.sv
// fci_win: block-add time-out window counter
`timescale 1ns/1ps
module fci_win #(
  parameter int CYC = 3840
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  output logic win_open
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt;

  // reload on each block write, count down to zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= CW'(CYC);
    end else if (cnt != '0) begin
      cnt <= cnt - CW'(1);
    end
  end

  assign win_open = cnt != '0;

  win_close_a: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(win_open) |-> $past(cnt) == CW'(1) && !$past(start))
    else $error("window closed early");
endmodule // fci_win

// file: verification/fci_flash_model.sv
// fci_flash_model: behavioural flash device on the host port
`timescale 1ns/1ps
module fci_flash_model import fci_pkg::*; (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [23:0] fl_addr,
  input wire logic [15:0] fl_wdata,
  input wire logic fl_wr,
  input wire logic fl_rd,
  output logic [15:0] fl_rdata,
  output logic fl_ack
);
  logic [15:0] prot, last;
  logic win, err;
  logic [1:0] dly;
  logic [23:0] wa[$];
  logic [15:0] wd[$];
  // answer after a random wait; idle data flips each cycle
  // gaps, dummy data
  always @(posedge mclk) begin
    fl_ack <= 1'b0;
    fl_rdata <= ~fl_rdata;
    if (!rstn) begin
      prot <= 16'hFFFF;
      last <= 16'h0000;
      win <= 1'b0;
      err <= 1'b0;
      dly <= 2'h0;
      fl_rdata <= 16'h5A5A;
    end else if ((fl_wr || fl_rd) && !fl_ack) begin
      if (dly != 2'h0) begin
        dly <= dly - 2'h1;
      end else begin
        fl_ack <= 1'b1;
        dly <= 2'($urandom_range(0, 3));
        if (fl_wr) begin
          wa.push_back(fl_addr);
          wd.push_back(fl_wdata);
          last <= fl_wdata;
          win <= (fl_wdata == C_BLK);
          if (last == C_SETP) begin
            prot <= prot & fl_wdata;
            err <= |(fl_wdata & ~prot);
          end
        end else begin
          fl_rdata <= (last == C_RDP) ? prot : {10'h0, err, 1'b0, win, 3'h0};
        end
      end
    end
  end
endmodule // fci_flash_model

// file: verification/tb_top.sv
// tb_top: self-checking bench of the flash command host controller
`timescale 1ns/1ps
module tb_top import fci_pkg::*; ;
  localparam int WC = 20;
  logic mclk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, fl_wr, fl_rd, fl_ack, ime, rmp, sgd, ok;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] c;
  logic [23:0] fl_addr, ta;
  logic [15:0] fl_wdata, fl_rdata, pw, ep;
  int n_fail = 0, check_count = 0, k, n0;
  logic [3:0] top[7] = '{OP_RESET, OP_SUSP, OP_RESUME, OP_BTU, OP_CTU, OP_CTP, OP_CERASE};
  int tn[7] = '{3, 1, 1, 4, 1, 1, 6};
  logic [15:0] td[7] = '{C_RESET, C_SUSP, C_RESUME, C_BTU2, C_CTU, C_CTP, C_CHIP};
  // 25 ns clock
  always #12.5 mclk = ~mclk;
  fci_host #(.WIN_CYCLES(WC)) u_dut (.mclk, .rstn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .fl_addr, .fl_wdata, .fl_wr, .fl_rd, .fl_rdata, .fl_ack,
    .internal_memory_enable(ime), .low_block_remap(rmp), .segmentation_disable(sgd));
  fci_flash_model u_dev (.mclk, .rstn, .fl_addr, .fl_wdata, .fl_wr, .fl_rd, .fl_rdata,
    .fl_ack);
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tmo(input int n);
    if (n > 2000) begin
      n_fail++;
      $display("unexpected wait");
      finish_test();
    end
  endtask
  // bus write, aw and w offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      tmo(n);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      n++;
      tmo(n);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    rs = rresp;
  endtask
  // start an operation, wait for idle, compare error bits
  task automatic go(input logic [3:0] op, input logic [3:0] ee);
    int n;
    n0 = u_dev.wd.size();
    wr(REG_CTRL, 32'h100 | 32'(op), RESP_OKAY);
    n = 0;
    do begin
      rd(REG_STAT);
      n++;
      tmo(n);
    end while (v[ST_BUSY] !== 1'b0);
    chk("err", 32'(v[4:1]), 32'(ee));
  endtask
  task automatic ew(input int i, input logic [23:0] a, input logic [15:0] d);
    chk("addr", 32'(u_dev.wa[n0+i]), 32'(a));
    chk("data", 32'(u_dev.wd[n0+i]), 32'(d));
  endtask
  function automatic logic [23:0] cb(input logic [15:0] o);
    return {8'h02, o};
  endfunction
  function automatic logic mp(input logic [23:0] a, input logic [2:0] g);
    return g[0] && ((g[1] ? a < 24'h008000 : (a >= 24'h010000 && a < 24'h018000))
      || (a >= 24'h018000 && a <= 24'h04FFFF));
  endfunction
  // main sequence
  initial begin
    void'($urandom(32'h1c1d8f69));
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rd(REG_SCFG);
    chk("scfg", v, 32'h0);
    rd(8'h18);
    chk("rresp", 32'(rs), 32'(RESP_SLVERR));
    wr(REG_STAT, 32'h1, RESP_SLVERR);
    wr(REG_CSEG, 32'h2, RESP_OKAY);
    for (k = 0; k < 10; k++) begin
      c = {2'($urandom_range(0, 3)), k != 0};
      ta = 24'($urandom_range(0, 32'h5FFFF)) & 24'hFFFFFE;
      pw = 16'($urandom);
      wr(REG_SCFG, 32'(c), RESP_OKAY);
      chk("cfg", {29'h0, sgd, rmp, ime}, 32'(c));
      wr(REG_TADDR, 32'(ta), RESP_OKAY);
      wr(REG_DATA, 32'(pw), RESP_OKAY);
      ok = mp(ta, c) && mp(cb(OFF_A), c);
      go(OP_PROG, ok ? 4'h0 : 4'h1);
      chk("nwr", 32'(u_dev.wd.size() - n0), ok ? 32'h4 : 32'h0);
      if (ok) begin
        ew(0, cb(OFF_A), C_UNLK1);
        ew(1, cb(OFF_B), C_UNLK2);
        ew(2, cb(OFF_A), C_PROG);
        ew(3, ta, pw);
      end
    end
    wr(REG_SCFG, 32'h3, RESP_OKAY);
    wr(REG_TADDR, 32'h021000, RESP_OKAY);
    go(OP_SETP, 4'h2);
    wr(REG_TADDR, 32'h021002, RESP_OKAY);
    pw = 16'($urandom) & 16'h7FFF;
    ep = 16'hFFFF & pw;
    wr(REG_DATA, 32'(pw), RESP_OKAY);
    go(OP_SETP, 4'h0);
    ew(0, cb(OFF_C), C_UNLK1);
    ew(2, cb(OFF_C), C_SETP);
    ew(3, 24'h021002, pw);
    wr(REG_TADDR, 32'h021006, RESP_OKAY);
    go(OP_RDP, 4'h0);
    chk("prot", 32'(v[31:16]), 32'(ep));
    // ones over programmed zeros: error flagged, register kept
    wr(REG_DATA, 32'hFFFF, RESP_OKAY);
    go(OP_SETP, 4'h0);
    go(OP_READ, 4'h0);
    chk("fsb_err", 32'(v[ST_RD_LSB+5]), 32'h1);
    go(OP_RDP, 4'h0);
    chk("prot", 32'(v[31:16]), 32'(ep));
    go(OP_ADDBLK, 4'h4);
    wr(REG_TADDR, 32'h020000, RESP_OKAY);
    go(OP_BERASE, 4'h0);
    ew(5, 24'h020000, C_BLK);
    chk("win", 32'(v[ST_WIN]), 32'h1);
    chk("erase", 32'(v[ST_ERASE]), 32'h1);
    wr(REG_TADDR, 32'h030000, RESP_OKAY);
    go(OP_ADDBLK, 4'h0);
    ew(0, 24'h030000, C_BLK);
    go(OP_READ, 4'h0);
    chk("fsb_win", 32'(v[ST_RD_LSB+3]), 32'h1);
    // byte 0 masked: the stored read operation runs again
    wstrb <= 4'h2;
    go(4'hD, 4'h0);
    wstrb <= 4'hF;
    chk("fsb_win", 32'(v[ST_RD_LSB+3]), 32'h1);
    repeat (WC + 5) @(posedge mclk);
    rd(REG_STAT);
    chk("win", 32'(v[ST_WIN]), 32'h0);
    go(OP_ADDBLK, 4'h4);
    go(4'hD, 4'h8);
    for (k = 0; k < 7; k++) begin
      go(top[k], 4'h0);
      chk("nwr", 32'(u_dev.wd.size() - n0), 32'(tn[k]));
      chk("last", 32'(u_dev.wd[n0+tn[k]-1]), 32'(td[k]));
    end
    finish_test();
  end
endmodule // tb_top
